// ==== pkg/sma_pkg.sv ====
// Shared constants of the system memory arbiter
package sma_pkg;
	localparam int NUM_REQ = 7;
	localparam int NUM_PER = 5;
	localparam int NUM_REG = 3;
	localparam int PRIO_W = 3;
	localparam int IDX_W = 3;
	localparam int KEY_W = PRIO_W + IDX_W;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h7;
	localparam logic [IDX_W-1:0] REQ_ISR = 3'h0;
	localparam logic [IDX_W-1:0] REQ_MAIN = 3'h1;
	localparam int PER_BASE = 2;
	localparam logic [1:0] REGION_FLASH = 2'h0;
	localparam logic [1:0] REGION_DATA = 2'h1;
	localparam logic [1:0] REGION_EE = 2'h2;
	localparam logic [7:0] OFS_PRIO_BASE = 8'h00;
	localparam logic [7:0] OFS_LOCK = 8'h1C;
	localparam logic [7:0] OFS_KEY = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
	localparam int LOCK_BIT = 0;
	localparam int ST_LOCK = 0;
	localparam int ST_GRANT = 1;
	localparam int ST_STALL = 6;
	localparam int ST_ISR = 7;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : sma_pkg

// ==== pkg/sma_pick_if.sv ====
// Candidate set and winner of one memory region
`timescale 1ns/1ps
`default_nettype none
interface sma_pick_if #(parameter int N = 6, parameter int KW = 6);
	logic [N-1:0] valid;
	logic [N-1:0][KW-1:0] key;
	logic [N-1:0] win;
	modport arb (output valid, output key, input win);
	modport pick (input valid, input key, output win);
endinterface : sma_pick_if
`default_nettype wire

// ==== src/sma_prio_pick.sv ====
// Picks the most urgent valid candidate of one region
`timescale 1ns/1ps
`default_nettype none
module sma_prio_pick #(
	parameter int N = 6,
	parameter int KW = 6
) (
	sma_pick_if.pick pif
);
	logic found;
	logic [KW-1:0] best;
	logic [N-1:0] win_next;

	always_comb begin
		found = 1'b0;
		best = '1;
		win_next = '0;
		for (int i = 0; i < N; i++) begin
			if (pif.valid[i] && (!found || pif.key[i] < best)) begin
				found = 1'b1;
				best = pif.key[i];
				win_next = '0;
				win_next[i] = 1'b1;
			end
		end
	end

	assign pif.win = win_next;
endmodule : sma_prio_pick
`default_nettype wire

// ==== src/sma_lock_seq.sv ====
// Key sequence guarding the priority lock bit
`timescale 1ns/1ps
`default_nettype none
module sma_lock_seq (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_take,
	input wire logic hit_key,
	input wire logic hit_lock,
	input wire logic [7:0] wdata,
	output logic lock
);
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_KEY1 = 3'b010,
		SEQ_ARMED = 3'b100
	} sma_seq_e;

	sma_seq_e state_reg;
	sma_seq_e state_next;
	logic lock_reg;
	logic lock_next;
	logic key1_seen;
	logic key2_seen;

	assign key1_seen = hit_key && wdata == sma_pkg::UNLOCK_KEY1;
	assign key2_seen = hit_key && wdata == sma_pkg::UNLOCK_KEY2;

	always_comb begin
		state_next = state_reg;
		lock_next = lock_reg;
		if (wr_take) begin
			state_next = SEQ_IDLE;
			case (state_reg)
				SEQ_IDLE: begin
					if (key1_seen)
						state_next = SEQ_KEY1;
				end
				SEQ_KEY1: begin
					if (key2_seen)
						state_next = SEQ_ARMED;
					else if (key1_seen)
						state_next = SEQ_KEY1;
				end
				SEQ_ARMED: begin
					if (hit_lock)
						lock_next = wdata[sma_pkg::LOCK_BIT];
					else if (key1_seen)
						state_next = SEQ_KEY1;
				end
				default: state_next = SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SEQ_IDLE;
			lock_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			lock_reg <= lock_next;
		end
	end

	assign lock = lock_reg;
endmodule : sma_lock_seq
`default_nettype wire

// ==== src/sma_arbiter.sv ====
// System memory arbiter with Avalon-MM register slave
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sma_arbiter #(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cpu_in_isr,
	input wire logic cpu_need_flash,
	input wire logic cpu_need_data,
	input wire logic cpu_need_ee,
	input wire logic flash_op_busy,
	input wire logic ee_op_busy,
	input wire logic [sma_pkg::NUM_PER-1:0] per_req,
	input wire logic [2*sma_pkg::NUM_PER-1:0] per_region,
	output logic [sma_pkg::NUM_PER-1:0] per_grant,
	output logic cpu_stall,
	output logic [sma_pkg::NUM_REG-1:0] cpu_region_ok
);
	localparam int NP = sma_pkg::NUM_PER;
	localparam int NR = sma_pkg::NUM_REG;
	localparam int KW = sma_pkg::KEY_W;
	localparam int PW = sma_pkg::PRIO_W;
	localparam int IW = sma_pkg::IDX_W;

	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("ADDR_W must lie between 8 and 32");
		end
	endgenerate

	// Bus slave state
	logic wait_reg;
	logic wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] rd_mux;
	logic [7:0] byte_addr;
	logic upper_zero;
	logic req_any;
	logic wr_take;
	logic rd_launch;
	logic hit_key;
	logic hit_lock;
	logic hit_status;
	logic [sma_pkg::NUM_REQ-1:0] hit_prio;
	logic prio_hit_any;
	logic [IW-1:0] prio_sel;

	// Arbitration state
	logic lock;
	logic [PW-1:0] prio_reg [sma_pkg::NUM_REQ];
	logic [IW-1:0] cpu_idx;
	logic [KW-1:0] cpu_key;
	logic [NR-1:0] cpu_need;
	logic [NR-1:0] region_blocked;
	logic [NP-1:0] per_elig;
	logic [NP-1:0] per_over;
	logic [NP-1:0][KW-1:0] per_key;
	logic [NP-1:0][NR-1:0] per_win;
	logic [NR-1:0] cpu_win;
	logic cpu_held;
	logic [NP-1:0] grant_next;
	logic [NP-1:0] grant_reg;
	logic stall_reg;
	logic [NR-1:0] cpu_ok_reg;
	logic [NR-1:0] cpu_ok_next;

	// Address decode
	assign req_any = avs_read || avs_write;
	assign wr_take = avs_write && !wait_reg;
	assign rd_launch = avs_read && wait_reg;
	assign byte_addr = avs_address[7:0];
	generate
		if (ADDR_W > 8) begin : g_upper
			assign upper_zero = ~|avs_address[ADDR_W-1:8];
		end else begin : g_no_upper
			assign upper_zero = 1'b1;
		end
	endgenerate
	assign hit_key = upper_zero && byte_addr == sma_pkg::OFS_KEY;
	assign hit_lock = upper_zero && byte_addr == sma_pkg::OFS_LOCK;
	assign hit_status = upper_zero && byte_addr == sma_pkg::OFS_STATUS;

	genvar gi;
	generate
		for (gi = 0; gi < sma_pkg::NUM_REQ; gi++) begin : g_hit
			assign hit_prio[gi] = upper_zero && byte_addr ==
				sma_pkg::OFS_PRIO_BASE + 8'(4 * gi);
		end
	endgenerate
	assign prio_hit_any = |hit_prio;

	always_comb begin
		prio_sel = '0;
		for (int i = 0; i < sma_pkg::NUM_REQ; i++) begin
			if (hit_prio[i])
				prio_sel = IW'(i);
		end
	end

	// One wait cycle per access keeps the read mux off the bus path
	assign wait_next = !(req_any && wait_reg);

	always_comb begin
		rd_mux = sma_pkg::RD_ZERO;
		if (prio_hit_any) begin
			rd_mux[PW-1:0] = prio_reg[prio_sel];
		end else if (hit_lock) begin
			rd_mux[sma_pkg::LOCK_BIT] = lock;
		end else if (hit_status) begin
			rd_mux[sma_pkg::ST_LOCK] = lock;
			rd_mux[sma_pkg::ST_GRANT +: NP] = grant_reg;
			rd_mux[sma_pkg::ST_STALL] = stall_reg;
			rd_mux[sma_pkg::ST_ISR] = cpu_in_isr;
		end
	end

	assign rdata_next = rd_launch ? rd_mux : rdata_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
			rdata_reg <= sma_pkg::RD_ZERO;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	sma_lock_seq u_lock (
		.clock(clock),
		.rst_n(rst_n),
		.wr_take(wr_take),
		.hit_key(hit_key),
		.hit_lock(hit_lock),
		.wdata(avs_writedata[7:0]),
		.lock(lock)
	);

	// Priority settings, one per requestor
	generate
		for (gi = 0; gi < sma_pkg::NUM_REQ; gi++) begin : g_prio
			logic prio_we;
			assign prio_we = wr_take && hit_prio[gi] && !lock;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n)
					prio_reg[gi] <= sma_pkg::PRIO_RESET;
				else if (prio_we)
					prio_reg[gi] <= avs_writedata[PW-1:0];
			end
		end
	endgenerate

	assign cpu_idx = cpu_in_isr ? sma_pkg::REQ_ISR : sma_pkg::REQ_MAIN;
	assign cpu_key = {prio_reg[cpu_idx], cpu_idx};

	assign cpu_need[sma_pkg::REGION_FLASH] = cpu_need_flash;
	assign cpu_need[sma_pkg::REGION_DATA] = cpu_need_data;
	assign cpu_need[sma_pkg::REGION_EE] = cpu_need_ee;

	assign region_blocked[sma_pkg::REGION_FLASH] = flash_op_busy;
	assign region_blocked[sma_pkg::REGION_DATA] = 1'b0;
	assign region_blocked[sma_pkg::REGION_EE] = ee_op_busy;

	generate
		for (gi = 0; gi < NP; gi++) begin : g_per
			logic [1:0] reg_sel;
			logic reg_valid;
			assign reg_sel = per_region[2*gi +: 2];
			assign reg_valid = reg_sel < 2'(NR);
			assign per_key[gi] = {prio_reg[gi + sma_pkg::PER_BASE],
				IW'(gi + sma_pkg::PER_BASE)};
			assign per_elig[gi] = lock && per_req[gi] && reg_valid &&
				!region_blocked[reg_sel];
			assign per_over[gi] = per_elig[gi] && per_key[gi] < cpu_key;
		end
	endgenerate

	assign cpu_held = |per_over;

	// Per region contest: slot 0 is the CPU, the rest peripherals
	generate
		for (gi = 0; gi < NR; gi++) begin : g_region
			sma_pick_if #(.N(NP + 1), .KW(KW)) pif ();
			assign pif.valid[0] = cpu_need[gi] && !cpu_held;
			assign pif.key[0] = cpu_key;
			for (genvar gp = 0; gp < NP; gp++) begin : g_cand
				assign pif.valid[gp + 1] = per_elig[gp] &&
					per_region[2*gp +: 2] == 2'(gi);
				assign pif.key[gp + 1] = per_key[gp];
				assign per_win[gp][gi] = pif.win[gp + 1];
			end
			assign cpu_win[gi] = pif.win[0];
			sma_prio_pick #(.N(NP + 1), .KW(KW)) u_pick (
				.pif(pif.pick)
			);
		end
	endgenerate

	generate
		for (gi = 0; gi < NP; gi++) begin : g_grant
			assign grant_next[gi] = |per_win[gi];
		end
	endgenerate

	assign cpu_ok_next = cpu_win;

	// Registered grants: decision lands one cycle after the request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			grant_reg <= '0;
			stall_reg <= 1'b0;
			cpu_ok_reg <= '0;
		end else begin
			grant_reg <= grant_next;
			stall_reg <= cpu_held;
			cpu_ok_reg <= cpu_ok_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign per_grant = grant_reg;
	assign cpu_stall = stall_reg;
	assign cpu_region_ok = cpu_ok_reg;
endmodule : sma_arbiter
`default_nettype wire

// ==== verification/sma_arbiter_checker.sv ====
// Port assertions for the memory arbiter
`timescale 1ns/1ps
`default_nettype none
module sma_checker #(parameter int ADDR_W = 8) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic flash_op_busy,
	input wire logic ee_op_busy,
	input wire logic [4:0] per_req,
	input wire logic [9:0] per_region,
	input wire logic [4:0] per_grant,
	input wire logic cpu_stall,
	input wire logic [2:0] cpu_region_ok
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic rd_done = avs_read && !avs_waitrequest;
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad wait");
	a_prio_upper_zero: assert property (rd_done && avs_address < 8'h1C
		|-> avs_readdata[31:3] == 29'h0) else $error("prio upper bits");
	a_unmapped_zero: assert property (rd_done && avs_address > 8'h24
		|-> avs_readdata == 32'h0) else $error("unmapped data");
	a_unlocked_idle: assert property (rd_done && avs_address == 8'h24
		&& !avs_readdata[0] |-> avs_readdata[6:1] == 6'h0) else $error("grant unlocked");
	a_flash_busy: assert property (flash_op_busy && per_region[1:0] == 2'h0
		|=> !per_grant[0]) else $error("flash busy grant");
	a_ee_busy: assert property (ee_op_busy && per_region[1:0] == 2'h2
		|=> !per_grant[0]) else $error("ee busy grant");
	a_grant_has_req: assert property (!per_req[0] |=> !per_grant[0])
		else $error("grant without request");
	a_stall_cause: assert property (cpu_stall
		|-> cpu_region_ok == 3'h0 && per_grant != 5'h0) else $error("bad stall");
	c_stall: cover property (cpu_stall);
	c_idle_grant: cover property (per_grant[0] && !cpu_stall);
	c_status: cover property (rd_done && avs_address == 8'h24);
endmodule : sma_checker
bind sma_arbiter sma_checker #(.ADDR_W(ADDR_W)) sma_checker_inst (
	.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .flash_op_busy(flash_op_busy),
	.ee_op_busy(ee_op_busy), .per_req(per_req), .per_region(per_region),
	.per_grant(per_grant), .cpu_stall(cpu_stall), .cpu_region_ok(cpu_region_ok));
`default_nettype wire

// ==== verification/sma_partner.sv ====
// Peripheral bus masters facing the arbiter
`timescale 1ns/1ps
`default_nettype none
module sma_partner #(parameter int LEN = 64) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [4:0] want,
	input wire logic [9:0] region,
	input wire logic [4:0] per_grant,
	output logic [4:0] per_req,
	output logic [9:0] per_region
);
	int cnt [5];
	always_ff @(posedge clock or negedge rst_n) begin
		for (int p = 0; p < 5; p++) begin
			if (!rst_n || !want[p]) cnt[p] <= 0;
			else if (per_grant[p]) cnt[p] <= cnt[p] + 1;
		end
	end
	// Request held until the burst ends
	always_comb begin
		for (int p = 0; p < 5; p++) begin
			per_req[p] = want[p] && cnt[p] < LEN;
			// Idle lines show the inverse, never a stale code
			per_region[2*p +: 2] = per_req[p] ? region[2*p +: 2] : ~region[2*p +: 2];
		end
	end
endmodule : sma_partner
`default_nettype wire

// ==== verification/test_system_memory_arbiter.sv ====
// Self-checking bench of the memory arbiter
`timescale 1ns/1ps
`default_nettype none
module test_system_memory_arbiter;
	logic clock = 0, rst_n = 0, avs_read = 0, avs_write = 0;
	logic [7:0] avs_address = 8'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
	logic avs_waitrequest, cpu_stall;
	logic [5:0] cpu = 6'h0;
	logic [4:0] want = 5'h0, per_req, per_grant;
	logic [9:0] region = 10'h0, per_region;
	logic [2:0] cpu_region_ok;
	logic [31:0] q [$];
	int error_cnt = 0, samples_checked = 0, seed = 74744;
	always #2 clock = ~clock;
	sma_arbiter sma_arbiter_inst (.clock(clock), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpu_in_isr(cpu[5]),
		.cpu_need_flash(cpu[4]), .cpu_need_data(cpu[3]), .cpu_need_ee(cpu[2]),
		.flash_op_busy(cpu[1]), .ee_op_busy(cpu[0]), .per_req(per_req),
		.per_region(per_region), .per_grant(per_grant), .cpu_stall(cpu_stall),
		.cpu_region_ok(cpu_region_ok));
	sma_partner sma_partner_inst (.clock(clock), .rst_n(rst_n), .want(want),
		.region(region), .per_grant(per_grant), .per_req(per_req),
		.per_region(per_region));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	always @(posedge clock) begin
		if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, q.pop_front());
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) error_cnt++;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic lock(input logic b);
		// key pair right before the lock write
		bus(1'b1, 8'h20, {24'h0, sma_pkg::UNLOCK_KEY1});
		bus(1'b1, 8'h20, {24'h0, sma_pkg::UNLOCK_KEY2});
		bus(1'b1, 8'h1C, {31'h0, b});
	endtask : lock
	task automatic run(input logic [20:0] p, input logic [5:0] c,
		input logic [4:0] w, input logic [9:0] r, input logic [7:0] e,
		input logic [2:0] o, input logic l);
		lock(1'b0);
		for (int i = 0; i < 7; i++) bus(1'b1, 8'(4 * i), {29'h0, p[3*i +: 3]});
		lock(l);
		@(posedge clock);
		cpu <= c;
		want <= w;
		region <= r;
		repeat (3) @(posedge clock);
		check({29'h0, cpu_region_ok}, {29'h0, o});
		rd(8'h24, {24'h0, e});
		want <= 5'h0;
		cpu <= 6'h0;
		$display("case done at %0t", $time);
	endtask : run
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h7);
		rd(8'h20, 32'h0);
		rd(8'h28, 32'h0);
		for (int i = 0; i < 7; i++) begin
			v = $random(seed);
			bus(1'b1, 8'(4 * i), v);
			rd(8'(4 * i), v & 32'h7);
		end
		lock(1'b1);
		bus(1'b1, 8'h18, ~v);
		rd(8'h18, v & 32'h7);
		bus(1'b1, 8'h1C, 32'h0);
		rd(8'h1C, 32'h1);
		$display("register test done");
		run(21'h1FFE3F, 6'h08, 5'h01, 10'h3FD, 8'h00, 3'h2, 1'b0);
		run(21'h1FFE3F, 6'h08, 5'h01, 10'h3FD, 8'h43, 3'h0, 1'b1);
		run(21'h1FFFFF, 6'h08, 5'h01, 10'h3FD, 8'h01, 3'h2, 1'b1);
		run(21'h1FFFFF, 6'h00, 5'h01, 10'h3FD, 8'h03, 3'h0, 1'b1);
		run(21'h1FFFFF, 6'h02, 5'h01, 10'h3FC, 8'h01, 3'h0, 1'b1);
		run(21'h1FFFFF, 6'h10, 5'h01, 10'h3FC, 8'h01, 3'h1, 1'b1);
		run(21'h1FFFFF, 6'h00, 5'h01, 10'h3FC, 8'h03, 3'h0, 1'b1);
		run(21'h1FFFFF, 6'h01, 5'h01, 10'h3FE, 8'h01, 3'h0, 1'b1);
		run(21'h1FFFFF, 6'h00, 5'h01, 10'h3FE, 8'h03, 3'h0, 1'b1);
		run(21'h1FFFFF, 6'h04, 5'h01, 10'h3FE, 8'h01, 3'h4, 1'b1);
		run(21'h1FFEF8, 6'h28, 5'h01, 10'h3FD, 8'h81, 3'h2, 1'b1);
		run(21'h1FFEF8, 6'h08, 5'h01, 10'h3FD, 8'h43, 3'h0, 1'b1);
		run(21'h1FF4BF, 6'h08, 5'h13, 10'h2F5, 8'h63, 3'h0, 1'b1);
		finish_test();
	end
endmodule : test_system_memory_arbiter
`default_nettype wire
